/* logic/timer_pair.sv */
// Timer pair: two 16-bit timers or one cascaded 32-bit timer/counter.
//
// What this block does
// - Two independent 16-bit timers or synchronous counters; no asynchronous counting.
// - In 32-bit mode the lower timer is the low word, upper the high word.
// - In 32-bit mode upper control is ignored; lower control, clock and gate rule.
// - In 32-bit mode the upper flag carries the interrupt, gated by upper enable.
// - In 16-bit mode only the lower timer registers its prescaler output.
// - 32-bit timer mode counts instruction cycles to the period, then wraps to zero.
// - Reading the low count latches the high count into the holding register.
// - Writing the low count in 32-bit mode loads the high count from holding.
// - 32-bit counter mode counts synchronised rising pin edges up to the period.
// - Counter stops during idle when stop-in-idle is set, else keeps counting.
// - Gated mode counts instruction cycles only while the gate pin is high.
// - In 32-bit gated mode the lower timer clocks and upper gate enable is ignored.
// - Gate falling edge ends accumulation without clearing the count.
// - Upper timer triggers the converter on 32-bit or own 16-bit period match.
// - Prescaler divides by 1, 8, 64 or 256 from control bits 5:4.
// - In 32-bit mode only the lower prescaler clocks the count.
// - Count or control writes, and reset, clear the prescaler.
// - A disabled timer's prescaler is not cleared by count or control writes; reset still clears it.
// - Control writes leave the counts unchanged.
// - 32-bit period match or gate fall sets the upper flag; software clears it.
// - Nothing counts while the CPU sleeps.
`timescale 1ns/1ps
`default_nettype none
module timer_pair
  import timer_pair_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  // Software writes and reads.
  input  wire logic [15:0] wr_data_i,
  input  wire logic        low_ctl_wr_i,
  input  wire logic        high_ctl_wr_i,
  input  wire logic        low_count_wr_i,
  input  wire logic        high_count_wr_i,
  input  wire logic        holding_wr_i,
  input  wire logic        low_period_wr_i,
  input  wire logic        high_period_wr_i,
  input  wire logic        low_count_rd_i,
  // CPU power state.
  input  wire logic        cpu_idle_i,
  input  wire logic        cpu_sleep_i,
  // Pins.
  input  wire logic        ext_clock_gate_pin_i,
  input  wire logic        high_ext_pin_i,
  // Interrupt flag control.
  input  wire logic        low_irq_clear_i,
  input  wire logic        high_irq_clear_i,
  input  wire logic        low_irq_enable_i,
  input  wire logic        high_timer_irq_enable_i,
  // Register contents.
  output logic [15:0]      low_timer_control_o,
  output logic [15:0]      high_timer_control_o,
  output logic [15:0]      low_count_o,
  output logic [15:0]      high_count_o,
  output logic [15:0]      high_word_holding_o,
  output logic [15:0]      low_period_o,
  output logic [15:0]      high_period_o,
  // Events.
  output logic             low_irq_flag_o,
  output logic             high_timer_irq_flag_o,
  output logic             low_irq_req_o,
  output logic             high_irq_req_o,
  output logic             adc_trigger_o
);

  logic        lo_pin;
  logic        hi_pin;
  logic        lo_pin_q;
  logic        hi_pin_q;
  logic        wide;
  logic        lo_on;
  logic        hi_on;
  logic        lo_run;
  logic        hi_run;
  logic        lo_src;
  logic        hi_src;
  logic        lo_clr;
  logic        hi_clr;
  logic        lo_ps_tick;
  logic        hi_ps_tick;
  logic        lo_tick;
  logic        hi_tick;
  logic        match32;
  logic        lo_match;
  logic        hi_match;
  logic        wide_hit;
  logic        lo_hit;
  logic        hi_hit;
  logic        lo_gate_fall;
  logic        hi_gate_fall;
  logic        any_cnt_wr;

  // Pins come from outside the clock domain.
  pin_sync u_lo_sync (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pin_i     (ext_clock_gate_pin_i),
    .sync_o    (lo_pin)
  );

  pin_sync u_hi_sync (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pin_i     (high_ext_pin_i),
    .sync_o    (hi_pin)
  );

  // Previous synchronised pin levels for edge detection.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      lo_pin_q <= 1'b0;
      hi_pin_q <= 1'b0;
    end else begin
      lo_pin_q <= lo_pin;
      hi_pin_q <= hi_pin;
    end
  end

  // Mode decode; the upper control is dead while the pair is cascaded.
  assign wide  = low_timer_control_o[CTL_WIDE_BIT];
  assign lo_on = low_timer_control_o[CTL_ON_BIT];
  assign hi_on = high_timer_control_o[CTL_ON_BIT] & ~wide;
  assign lo_run = lo_on & ~cpu_sleep_i
                & ~(cpu_idle_i & low_timer_control_o[CTL_SIDL_BIT]);
  assign hi_run = hi_on & ~cpu_sleep_i
                & ~(cpu_idle_i & high_timer_control_o[CTL_SIDL_BIT]);

  // Clock source: synchronised rising edge, gated cycles, or every cycle.
  // Edges are always synchronised, so no asynchronous counting exists.
  assign lo_src = low_timer_control_o[CTL_CS_BIT] ? (lo_pin & ~lo_pin_q)
                : (low_timer_control_o[CTL_GATE_BIT] ? lo_pin : 1'b1);
  assign hi_src = high_timer_control_o[CTL_CS_BIT] ? (hi_pin & ~hi_pin_q)
                : (high_timer_control_o[CTL_GATE_BIT] ? hi_pin : 1'b1);

  // Prescaler clears; when cascaded the upper writes also restart the lower one.
  assign lo_clr = low_ctl_wr_i | low_count_wr_i
                | (wide & (high_ctl_wr_i | high_count_wr_i));
  assign hi_clr = high_ctl_wr_i | high_count_wr_i;

  timer_prescaler #(.SYNC_OUT(1'b1)) u_lo_ps (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .run_i     (lo_run),
    .on_i      (lo_on),
    .clear_i   (lo_clr),
    .select_i  (low_timer_control_o[CTL_PS_HI_BIT:CTL_PS_LO_BIT]),
    .tick_i    (lo_src),
    .tick_o    (lo_ps_tick)
  );

  timer_prescaler #(.SYNC_OUT(1'b0)) u_hi_ps (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .run_i     (hi_run),
    .on_i      (high_timer_control_o[CTL_ON_BIT]),
    .clear_i   (hi_clr),
    .select_i  (high_timer_control_o[CTL_PS_HI_BIT:CTL_PS_LO_BIT]),
    .tick_i    (hi_src),
    .tick_o    (hi_ps_tick)
  );

  // A registered tick may trail a disable by one cycle, so it is masked.
  assign lo_tick = lo_ps_tick & lo_run;
  assign hi_tick = hi_ps_tick & hi_run;

  // Period compares and match events.
  assign match32  = {high_count_o, low_count_o} == {high_period_o, low_period_o};
  assign lo_match = low_count_o == low_period_o;
  assign hi_match = high_count_o == high_period_o;
  assign wide_hit = wide & lo_tick & match32;
  assign lo_hit   = ~wide & lo_tick & lo_match;
  assign hi_hit   = ~wide & hi_tick & hi_match;

  // Gate falls end an accumulation; they only count in gated internal mode.
  assign lo_gate_fall = lo_run & low_timer_control_o[CTL_GATE_BIT]
                      & ~low_timer_control_o[CTL_CS_BIT] & ~lo_pin & lo_pin_q;
  assign hi_gate_fall = hi_run & high_timer_control_o[CTL_GATE_BIT]
                      & ~high_timer_control_o[CTL_CS_BIT] & ~hi_pin & hi_pin_q;

  assign any_cnt_wr = low_count_wr_i | high_count_wr_i;

  // Control registers; writes touch no count.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      low_timer_control_o  <= CTL_RST;
      high_timer_control_o <= CTL_RST;
    end else begin
      if (low_ctl_wr_i) begin
        low_timer_control_o <= wr_data_i & LOW_CTL_MASK;
      end
      if (high_ctl_wr_i) begin
        high_timer_control_o <= wr_data_i & HIGH_CTL_MASK;
      end
    end
  end

  // Period registers.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      low_period_o  <= PERIOD_RST;
      high_period_o <= PERIOD_RST;
    end else begin
      if (low_period_wr_i) begin
        low_period_o <= wr_data_i;
      end
      if (high_period_wr_i) begin
        high_period_o <= wr_data_i;
      end
    end
  end

  // Low word: a software write wins over a tick in the same cycle.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      low_count_o <= COUNT_RST;
    end else if (low_count_wr_i) begin
      low_count_o <= wr_data_i;
    end else if (lo_tick) begin
      low_count_o <= (wide ? match32 : lo_match) ? COUNT_RST : low_count_o + 16'h0001;
    end
  end

  // High word: carries from the low word when cascaded, else counts alone.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      high_count_o <= COUNT_RST;
    end else if (high_count_wr_i) begin
      high_count_o <= wr_data_i;
    end else if (low_count_wr_i & wide) begin
      high_count_o <= high_word_holding_o;
    end else if (wide & lo_tick) begin
      if (match32) begin
        high_count_o <= COUNT_RST;
      end else if (low_count_o == 16'hffff) begin
        high_count_o <= high_count_o + 16'h0001;
      end
    end else if (hi_tick) begin
      high_count_o <= hi_match ? COUNT_RST : high_count_o + 16'h0001;
    end
  end

  // Holding register; a software write wins over a read capture.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      high_word_holding_o <= COUNT_RST;
    end else if (holding_wr_i) begin
      high_word_holding_o <= wr_data_i;
    end else if (low_count_rd_i) begin
      high_word_holding_o <= high_count_o;
    end
  end

  // Sticky flags: a setting event beats a clear in the same cycle.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      low_irq_flag_o        <= 1'b0;
      high_timer_irq_flag_o <= 1'b0;
    end else begin
      if (lo_hit | (~wide & lo_gate_fall)) begin
        low_irq_flag_o <= 1'b1;
      end else if (low_irq_clear_i) begin
        low_irq_flag_o <= 1'b0;
      end
      if (wide_hit | (wide & lo_gate_fall) | hi_hit | hi_gate_fall) begin
        high_timer_irq_flag_o <= 1'b1;
      end else if (high_irq_clear_i) begin
        high_timer_irq_flag_o <= 1'b0;
      end
    end
  end

  // Converter trigger is a one-cycle pulse after the match.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      adc_trigger_o <= 1'b0;
    end else begin
      adc_trigger_o <= wide_hit | hi_hit;
    end
  end

  // Requests follow the flags through their enables.
  assign low_irq_req_o  = low_irq_flag_o & low_irq_enable_i;
  assign high_irq_req_o = high_timer_irq_flag_o & high_timer_irq_enable_i;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  ctl_keeps_count_a: assert property (
    (low_ctl_wr_i | high_ctl_wr_i) & ~any_cnt_wr & ~lo_tick & ~hi_tick
    |=> $stable(low_count_o) && $stable(high_count_o))
    else $error("control write changed a count");

  wide_wrap_zero_a: assert property (
    wide_hit & ~any_cnt_wr |=> {high_count_o, low_count_o} == 32'h0000_0000)
    else $error("32-bit count did not wrap to zero");

  hold_capture_a: assert property (
    low_count_rd_i & ~holding_wr_i |=> high_word_holding_o == $past(high_count_o))
    else $error("holding register missed the high word");

  hold_transfer_a: assert property (
    low_count_wr_i & wide & ~high_count_wr_i
    |=> high_count_o == $past(high_word_holding_o) && low_count_o == $past(wr_data_i))
    else $error("coherent write did not load both words");

  idle_stop_a: assert property (
    cpu_idle_i & low_timer_control_o[CTL_SIDL_BIT] & wide & ~any_cnt_wr
    |=> $stable(low_count_o) && $stable(high_count_o))
    else $error("count moved in idle with stop set");

  sleep_freeze_a: assert property (
    cpu_sleep_i & ~any_cnt_wr |=> $stable(low_count_o) && $stable(high_count_o))
    else $error("count moved during sleep");

  off_no_trigger_a: assert property (
    ~lo_on & ~hi_on |=> ~adc_trigger_o)
    else $error("trigger raised while timers were off");

  wide_flag_a: assert property (
    wide & (wide_hit | lo_gate_fall) |=> high_timer_irq_flag_o)
    else $error("upper flag not set on 32-bit event");

  short_trigger_a: assert property (
    hi_hit |=> adc_trigger_o ##1 ~adc_trigger_o || $past(wide_hit | hi_hit, 1))
    else $error("16-bit match gave no single trigger");

  // The registered lower tick lands the last gated count in the fall cycle itself.
  gate_keeps_a: assert property (
    lo_gate_fall & ~low_count_wr_i ##1 ~low_count_wr_i |=> $stable(low_count_o))
    else $error("gate fall did not stop the count");

  upper_dead_a: assert property (
    wide |-> ~hi_tick && ~hi_gate_fall)
    else $error("upper timer active while cascaded");

  wide_wrap_c: cover property (wide_hit ##1 adc_trigger_o);
  half_wrap_c: cover property (hi_hit);
  gate_end_c: cover property (wide & lo_gate_fall);
  coherent_wr_c: cover property (holding_wr_i ##[1:4] (low_count_wr_i & wide));

endmodule
`default_nettype wire

/* pkg/timer_pair_pkg.sv */
// Constants shared by the dual 16-bit / cascaded 32-bit timer pair.
package timer_pair_pkg;

  // Control register field positions.
  localparam int CTL_ON_BIT    = 15;
  localparam int CTL_SIDL_BIT  = 13;
  localparam int CTL_GATE_BIT  = 6;
  localparam int CTL_PS_HI_BIT = 5;
  localparam int CTL_PS_LO_BIT = 4;
  localparam int CTL_WIDE_BIT  = 3;
  localparam int CTL_CS_BIT    = 1;

  // Implemented bits of each control register; the rest read as zero.
  localparam logic [15:0] LOW_CTL_MASK  = 16'ha07a;
  localparam logic [15:0] HIGH_CTL_MASK = 16'ha072;

  // Values after reset.
  localparam logic [15:0] CTL_RST    = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [7:0]  PS_CNT_RST = 8'h00;

  // Prescale select codes and the last prescaler count of each ratio.
  localparam logic [1:0] PS_SEL_1   = 2'h0;
  localparam logic [1:0] PS_SEL_8   = 2'h1;
  localparam logic [1:0] PS_SEL_64  = 2'h2;
  localparam logic [1:0] PS_SEL_256 = 2'h3;
  localparam logic [7:0] PS_LAST_1   = 8'h00;
  localparam logic [7:0] PS_LAST_8   = 8'h07;
  localparam logic [7:0] PS_LAST_64  = 8'h3f;
  localparam logic [7:0] PS_LAST_256 = 8'hff;

endpackage

/* logic/pin_sync.sv */
// Two-flop synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset.
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  // Asynchronous pin and its synchronised copy.
  input  wire logic pin_i,
  output logic      sync_o
);

  logic stage1;

  // The first stage is read only by the second one.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stage1 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      stage1 <= pin_i;
      sync_o <= stage1;
    end
  end

endmodule
`default_nettype wire

/* logic/timer_prescaler.sv */
// Clock prescaler with 1:1, 1:8, 1:64 and 1:256 ratios for one timer.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
  import timer_pair_pkg::*;
#(
  parameter bit SYNC_OUT = 1'b0
) (
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // Control.
  input  wire logic       run_i,
  input  wire logic       on_i,
  input  wire logic       clear_i,
  input  wire logic [1:0] select_i,
  // Input ticks and divided ticks.
  input  wire logic       tick_i,
  output logic            tick_o
);

  logic [7:0] cnt;
  logic [7:0] last;
  logic       hit;

  // Terminal count of the selected ratio.
  always_comb begin
    unique case (select_i)
      PS_SEL_1:   last = PS_LAST_1;
      PS_SEL_8:   last = PS_LAST_8;
      PS_SEL_64:  last = PS_LAST_64;
      PS_SEL_256: last = PS_LAST_256;
    endcase
  end

  assign hit = run_i & tick_i & (cnt == last);

  // A disabled timer has no prescaler clock, so a clear then has no effect.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt <= PS_CNT_RST;
    end else if (clear_i & on_i) begin
      cnt <= PS_CNT_RST;
    end else if (run_i & tick_i) begin
      cnt <= hit ? PS_CNT_RST : cnt + 8'h01;
    end
  end

  // The registered form costs one cycle of latency but gives a clean tick.
  generate
    if (SYNC_OUT) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          tick_o <= 1'b0;
        end else begin
          tick_o <= hit;
        end
      end
    end else begin : g_direct
      assign tick_o = hit;
    end
  endgenerate

endmodule
`default_nettype wire

/* bench/ext_pin_source.sv */
// Far-side source that drives the external clock or gate pin in bursts.
`timescale 1ns/1ps
`default_nettype none
module ext_pin_source (
  // Clock.
  input  wire logic       ref_clk_i,
  // Burst request: rising edges wanted and half period in cycles.
  input  wire logic       go_i,
  input  wire logic [7:0] edges_i,
  input  wire logic [7:0] half_i,
  // Pin level and activity.
  output logic            pin_o,
  output logic            busy_o
);
  logic [7:0] left;
  logic [7:0] phase;

  // The pin rests low between bursts, so no stray edge can reach the timer.
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    left = 8'h00;
    phase = 8'h00;
  end

  // Each edge is a low half then a high half; a one-edge burst is one gate window.
  always @(posedge ref_clk_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      left <= edges_i;
      phase <= 8'h00;
    end else if (busy_o) begin
      if (phase == half_i - 8'h01) begin
        phase <= 8'h00;
        pin_o <= ~pin_o;
        if (pin_o) begin
          left <= left - 8'h01;
          busy_o <= (left != 8'h01);
        end
      end else begin
        phase <= phase + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb_timer_pair.sv */
// Self-checking testbench for the timer pair and its pin source.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_pair;
  import timer_pair_pkg::*;
  localparam logic [6:0] S_LC = 7'h01, S_HC = 7'h02, S_LN = 7'h04, S_HN = 7'h08;
  localparam logic [6:0] S_HD = 7'h10, S_LP = 7'h20, S_HP = 7'h40;
  localparam logic [15:0] ON = 16'h0001 << CTL_ON_BIT, SIDL = 16'h0001 << CTL_SIDL_BIT;
  localparam logic [15:0] GATE = 16'h0001 << CTL_GATE_BIT, WIDE = 16'h0001 << CTL_WIDE_BIT;
  localparam logic [15:0] CS = 16'h0001 << CTL_CS_BIT;
  logic        ref_clk_i, srst_i, cpu_idle_i, cpu_sleep_i, high_ext_pin_i, go, busy;
  logic        low_irq_enable_i, high_timer_irq_enable_i, ext_clock_gate_pin_i;
  logic [6:0]  strb;
  logic [2:0]  pl;
  logic [7:0]  edges, half;
  logic [15:0] wr_data_i, low_timer_control_o, high_timer_control_o, low_count_o, high_count_o;
  logic [15:0] high_word_holding_o, low_period_o, high_period_o;
  logic        low_irq_flag_o, high_timer_irq_flag_o, low_irq_req_o, high_irq_req_o, adc_trigger_o;
  int          miscompares = 0, tests_run = 0;
  // Strobes travel as bit vectors so one task can raise any mix of them.
  wire low_ctl_wr_i = strb[0], high_ctl_wr_i = strb[1], low_count_wr_i = strb[2];
  wire high_count_wr_i = strb[3], holding_wr_i = strb[4], low_period_wr_i = strb[5];
  wire high_period_wr_i = strb[6], low_count_rd_i = pl[0], low_irq_clear_i = pl[1];
  wire high_irq_clear_i = pl[2];
  wire [15:0] lcnt = low_count_o, hcnt = high_count_o;
  wire        trig = adc_trigger_o, hflag = high_timer_irq_flag_o;

  timer_pair u_timer_pair (.ref_clk_i, .srst_i, .wr_data_i, .low_ctl_wr_i, .high_ctl_wr_i,
    .low_count_wr_i, .high_count_wr_i, .holding_wr_i, .low_period_wr_i, .high_period_wr_i,
    .low_count_rd_i, .cpu_idle_i, .cpu_sleep_i, .ext_clock_gate_pin_i, .high_ext_pin_i,
    .low_irq_clear_i, .high_irq_clear_i, .low_irq_enable_i, .high_timer_irq_enable_i,
    .low_timer_control_o, .high_timer_control_o, .low_count_o, .high_count_o,
    .high_word_holding_o, .low_period_o, .high_period_o, .low_irq_flag_o,
    .high_timer_irq_flag_o, .low_irq_req_o, .high_irq_req_o, .adc_trigger_o);
  ext_pin_source u_ext_pin_source (.ref_clk_i, .go_i(go), .edges_i(edges), .half_i(half),
    .pin_o(ext_clock_gate_pin_i), .busy_o(busy));

  // Free-running 125 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Every polling wait goes through here, so a hang ends as a failure instead of a stuck run.
  task automatic step(inout int n);
    @(negedge ref_clk_i);
    n++;
    if (n > 4000) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wr(input logic [6:0] s, input logic [15:0] d);
    @(negedge ref_clk_i);
    strb = s;
    wr_data_i = d;
    @(negedge ref_clk_i);
    strb = 7'h00;
  endtask
  task automatic pulse(input logic [2:0] p);
    @(negedge ref_clk_i);
    pl = p;
    @(negedge ref_clk_i);
    pl = 3'h0;
  endtask
  function automatic logic [15:0] ps(input logic [1:0] k);
    return 16'(k) << CTL_PS_LO_BIT;
  endfunction
  // Cycles until the high count next moves; only the second of two calls is a clean gap.
  task automatic gap_h(output int n);
    logic [15:0] v;
    v = hcnt;
    n = 0;
    while (hcnt === v) step(n);
  endtask
  task automatic burst(input logic [7:0] e, input logic [7:0] h);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    edges = e;
    half = h;
    go = 1'b1;
    @(negedge ref_clk_i);
    go = 1'b0;
    while (busy === 1'b1) step(n);
    cyc(8);
  endtask

  task automatic t_reset();
    check({low_timer_control_o, high_timer_control_o}, {CTL_RST, CTL_RST});
    check({lcnt, hcnt}, {COUNT_RST, COUNT_RST});
    check({low_period_o, high_period_o}, {PERIOD_RST, PERIOD_RST});
    check({trig, hflag, low_irq_flag_o}, 3'h0);
  endtask
  task automatic t_period16();
    int n;
    logic [15:0] v;
    n = 0;
    wr(S_HP, 16'h0002);
    wr(S_HC, ON);
    while (trig !== 1'b1) step(n);
    check({hcnt, hflag, high_irq_req_o, low_irq_flag_o}, {16'h0000, 3'h6});
    n = 0;
    step(n);
    check(trig, 1'b0);
    while (trig !== 1'b1) step(n);
    check(n, 3);
    wr(S_HC, ps(2'h3));
    v = hcnt;
    n = 0;
    repeat (20) begin
      step(n);
      if (trig !== 1'b0) check(trig, 1'b0);
    end
    check(hcnt, v);
    pulse(3'h4);
    check(hflag, 1'b0);
  endtask
  task automatic t_prescale();
    int n;
    int d[2];
    int r[4] = '{1, 8, 64, 256};
    for (int k = 0; k < 4; k++) begin
      wr(S_HC, ON | ps(2'(k)));
      gap_h(n);
      gap_h(n);
      check(n, r[k]);
    end
    // A count write lands at two prescaler phases; clearing makes both waits equal.
    for (int i = 0; i < 2; i++) begin
      wr(S_HC, ON | ps(2'h1));
      cyc(3 + 2 * i);
      wr(S_HN, 16'h0000);
      n = 0;
      while (hcnt !== 16'h0001) step(n);
      d[i] = n;
    end
    check(d[1], d[0]);
  endtask
  task automatic t_sync16();
    wr(S_HC | S_LC, 16'h0000);
    wr(S_LN | S_HN, 16'h0000);
    wr(S_LP | S_HP, 16'hffff);
    wr(S_HC | S_LC, ON);
    cyc(10);
    check(hcnt - lcnt, 16'h0001);
  endtask
  task automatic t_wide();
    int n;
    wr(S_HC, ps(2'h3));
    wr(S_LC, WIDE);
    pulse(3'h4);
    wr(S_HP, 16'h0002);
    wr(S_LP, 16'h0001);
    wr(S_HD, 16'h0001);
    wr(S_LN, 16'hfffd);
    check({hcnt, lcnt}, 32'h0001fffd);
    wr(S_LC, WIDE | ON);
    n = 0;
    while (hcnt !== 16'h0002) step(n);
    check(lcnt, 16'h0000);
    n = 0;
    while (trig !== 1'b1) step(n);
    check(n, 2);
    check({hcnt, lcnt}, 32'h0000_0000);
    check({hflag, high_irq_req_o, low_irq_flag_o}, 3'h6);
    pulse(3'h1);
    check(high_word_holding_o, 16'h0000);
    wr(S_LC, 16'h0000);
    pulse(3'h4);
  endtask
  task automatic t_gate();
    logic [15:0] v;
    wr(S_LP, 16'hffff);
    wr(S_LN, 16'h0000);
    wr(S_LC, ON | GATE);
    burst(8'h01, 8'h14);
    v = lcnt;
    check(v > 16'h0012 && v < 16'h0016, 1'b1);
    check({low_irq_flag_o, low_irq_req_o}, 2'h3);
    cyc(10);
    check(lcnt, v);
    pulse(3'h2);
    check(low_irq_flag_o, 1'b0);
  endtask
  task automatic t_counter();
    wr(S_LC, WIDE);
    wr(S_LP | S_HP, 16'hffff);
    wr(S_HD, 16'h0000);
    wr(S_LN, 16'h0000);
    wr(S_LC, WIDE | ON | CS);
    burst(8'h05, 8'h03);
    check({hcnt, lcnt}, 32'h5);
    wr(S_LC, WIDE | ON | CS | SIDL);
    cpu_idle_i = 1'b1;
    burst(8'h04, 8'h03);
    check(lcnt, 16'h0005);
    wr(S_LC, WIDE | ON | CS);
    burst(8'h04, 8'h03);
    check(lcnt, 16'h0009);
    cpu_idle_i = 1'b0;
    cpu_sleep_i = 1'b1;
    burst(8'h03, 8'h03);
    check(lcnt, 16'h0009);
    cpu_sleep_i = 1'b0;
  endtask
  // The upper timer counts synchronised rising edges on its own pin in 16-bit mode.
  task automatic t_upper_pin();
    wr(S_LC, 16'h0000);
    wr(S_HP, 16'hffff);
    wr(S_HN, 16'h0000);
    wr(S_HC, ON | CS);
    repeat (3) begin
      cyc(3);
      high_ext_pin_i = 1'b1;
      cyc(3);
      high_ext_pin_i = 1'b0;
    end
    cyc(6);
    check(hcnt, 16'h0003);
    wr(S_HC, 16'h0000);
  endtask

  // Reset for three cycles, then the scenarios in turn.
  initial begin
    srst_i = 1'b1;
    strb = 7'h00;
    pl = 3'h0;
    wr_data_i = 16'h0000;
    cpu_idle_i = 1'b0;
    cpu_sleep_i = 1'b0;
    high_ext_pin_i = 1'b0;
    low_irq_enable_i = 1'b1;
    high_timer_irq_enable_i = 1'b1;
    go = 1'b0;
    edges = 8'h00;
    half = 8'h01;
    cyc(3);
    srst_i = 1'b0;
    t_reset();
    t_period16();
    t_prescale();
    t_sync16();
    t_wide();
    t_gate();
    t_counter();
    t_upper_pin();
    close_out();
  end
endmodule
`default_nettype wire
